// ==== bench/exec_chk.sv ====
// concurrent checks on the return and rotate execution block
// bound to the top module; sees its ports only, single clock domain
module exec_chk (
   // clock and reset
   input wire logic        SYS_CLK_I,
   input wire logic        RST_N_I,
   // register writes
   input wire logic        S_AXI_AWVALID_I,
   input wire logic        S_AXI_AWREADY_O,
   input wire logic [7:0]  S_AXI_AWADDR_I,
   input wire logic        S_AXI_WVALID_I,
   input wire logic        S_AXI_WREADY_O,
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic [3:0]  S_AXI_WSTRB_I,
   input wire logic        S_AXI_BVALID_O,
   // core state
   input wire logic [7:0]  ACC_O,
   input wire logic        CARRY_FLAG_O,
   input wire logic        REGISTER_BANK_FLAG_O,
   input wire logic [16:0] PC_O,
   input wire logic [15:0] SP_O,
   input wire logic [3:0]  INT_NEST_O,
   input wire logic        BUSY_O
);
   timeunit 1ns;
   timeprecision 100ps;
   logic       iss_q, iss_d;
   logic [7:0] op_q, op_d;

   // clear the highest level in service
   function automatic logic [3:0] pop(input logic [3:0] n);
      for (int i = 3; i >= 0; i--) if (n[i]) begin
         n[i] = 1'b0;
         return n;
      end
      return n;
   endfunction

   // remember target and opcode of the last write
   always_comb begin
      iss_d = iss_q;
      op_d  = op_q;
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) iss_d = (S_AXI_AWADDR_I == cpu_exec_pkg::ISSUE_OFS);
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) op_d = S_AXI_WSTRB_I[0] ? S_AXI_WDATA_I[7:0] : 8'h01;
   end
   always_ff @(posedge SYS_CLK_I) begin
      iss_q <= RST_N_I ? iss_d : 1'b0;
      op_q  <= RST_N_I ? op_d : 8'h01;
   end

   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_N_I);

   // an opcode issue completes
   sequence s_go(logic [7:0] o);
      $rose(S_AXI_BVALID_O) && iss_q && op_q == o && !$past(BUSY_O);
   endsequence

   a_rol_rotates: assert property (s_go(cpu_exec_pkg::OP_ROL) |->
      ACC_O == {$past(ACC_O[6:0]), $past(ACC_O[7])} && $stable(CARRY_FLAG_O)
      && $stable(REGISTER_BANK_FLAG_O)) else $error("rotate left wrong");
   a_rotate_left_through_carry_op_carry: assert property (s_go(cpu_exec_pkg::OP_ROTATE_LEFT_THROUGH_CARRY_OP) |->
      ACC_O == {$past(ACC_O[6:0]), $past(CARRY_FLAG_O)} && CARRY_FLAG_O == $past(ACC_O[7])
      && $stable(REGISTER_BANK_FLAG_O)) else $error("rotate left carry wrong");
   a_ror_rotates: assert property (s_go(cpu_exec_pkg::OP_ROR) |->
      ACC_O == {$past(ACC_O[0]), $past(ACC_O[7:1])} && $stable(CARRY_FLAG_O)
      && $stable(REGISTER_BANK_FLAG_O)) else $error("rotate right wrong");
   a_rotate_right_through_carry_op_carry: assert property (s_go(cpu_exec_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY_OP) |->
      ACC_O == {$past(CARRY_FLAG_O), $past(ACC_O[7:1])} && CARRY_FLAG_O == $past(ACC_O[0])
      && $stable(REGISTER_BANK_FLAG_O)) else $error("rotate right carry wrong");
   a_rot_pc_step: assert property ($rose(S_AXI_BVALID_O) && iss_q && op_q[3:0] == 4'h0
      && op_q[7:6] == 2'b11 |-> PC_O == $past(PC_O) + 17'h00001) else $error("pc step wrong");
   a_return_from_interrupt_op_start: assert property (s_go(cpu_exec_pkg::OP_RETURN_FROM_INTERRUPT_OP) |->
      BUSY_O && SP_O == $past(SP_O) - 16'h0001) else $error("return start wrong");
   a_return_from_interrupt_op_finish: assert property (BUSY_O |=> !BUSY_O
      && SP_O == $past(SP_O) - 16'h0001) else $error("return finish wrong");
   a_nest_pop: assert property (BUSY_O |=>
      INT_NEST_O == pop($past(INT_NEST_O))) else $error("nesting pop wrong");
endmodule // exec_chk

bind cpu_return_from_interrupt_op_and_rotate_exec exec_chk u_chk (.SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I),
   .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
   .S_AXI_AWADDR_I(S_AXI_AWADDR_I), .S_AXI_WVALID_I(S_AXI_WVALID_I),
   .S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_WDATA_I(S_AXI_WDATA_I),
   .S_AXI_WSTRB_I(S_AXI_WSTRB_I), .S_AXI_BVALID_O(S_AXI_BVALID_O), .ACC_O(ACC_O),
   .CARRY_FLAG_O(CARRY_FLAG_O), .REGISTER_BANK_FLAG_O(REGISTER_BANK_FLAG_O), .PC_O(PC_O),
   .SP_O(SP_O), .INT_NEST_O(INT_NEST_O), .BUSY_O(BUSY_O));

// ==== bench/testbench.sv ====
// self-checking bench for the return and rotate execution block
// drives the register bus itself; checker attaches by bind
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
   $display("unexpected %s exp %h got %h", nm, e, g); \
   fail_count++; end end
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, seed, v, w, d;
   logic [3:0]  wstrb;
   wire         awready, wready, bvalid, arready, rvalid, cy, bank, busy;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [7:0]  acc;
   wire  [16:0] pc;
   wire  [15:0] sp;
   wire  [3:0]  nest;
   int          fail_count, cmp_count, n;
   logic [7:0]  a, op;
   logic [8:0]  e, lo, hi;
   logic [15:0] s;
   logic [7:0]  ops [4] = '{8'he0, 8'hf0, 8'hc0, 8'hd0};

   cpu_return_from_interrupt_op_and_rotate_exec uut (.SYS_CLK_I(clk), .RST_N_I(rst_n),
      .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_AWADDR_I(awaddr),
      .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_WDATA_I(wdata),
      .S_AXI_WSTRB_I(wstrb), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
      .S_AXI_BRESP_O(bresp), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
      .S_AXI_ARADDR_I(araddr), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
      .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .ACC_O(acc), .CARRY_FLAG_O(cy),
      .REGISTER_BANK_FLAG_O(bank), .PC_O(pc), .SP_O(sp), .INT_NEST_O(nest), .BUSY_O(busy));

   // 25 ns core clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   function automatic logic [31:0] nxt();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction
   // expected {carry, acc} after a rotate
   function automatic logic [8:0] rot(logic [7:0] o, logic [7:0] x, logic c);
      case (o)
         8'he0: return {c, x[6:0], x[7]};
         8'hf0: return {x[7], x[6:0], c};
         8'hc0: return {c, x[0], x[7:1]};
         default: return {x[0], c, x[7:1]};
      endcase
   endfunction
   function automatic logic [3:0] pop(logic [3:0] m);
      for (int i = 3; i >= 0; i--) if (m[i]) begin
         m[i] = 1'b0;
         return m;
      end
      return m;
   endfunction

   task automatic complete_run();
      if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // one register write, address and data offered together
   task automatic axw(input logic [7:0] ad, input logic [31:0] dt, input logic [1:0] er);
      @(posedge clk);
      awaddr <= ad;
      wdata <= dt;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      if (n == 40) begin fail_count++; complete_run(); end
      `CHK("bresp", er, bresp)
   endtask
   // one register read
   task automatic axr(input logic [7:0] ad, input logic [1:0] er);
      @(posedge clk);
      araddr <= ad;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      d = rdata;
      if (n == 40) begin fail_count++; complete_run(); end
      `CHK("rresp", er, rresp)
   endtask

   // main sequence
   initial begin
      fail_count = 0;
      cmp_count = 0;
      seed = 32'h00000058;
      {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {awaddr, araddr, wdata, wstrb} = {16'h0000, 32'h00000000, 4'hf};
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      axw(8'h24, 32'h00000000, cpu_exec_pkg::RESP_ERR);
      axr(8'h24, cpu_exec_pkg::RESP_ERR);
      for (int i = 0; i < 48; i++) begin
         v = nxt();
         a = (i < 8) ? (i[0] ? 8'h80 : 8'h01) : v[7:0];
         op = ops[(i < 4) ? i[1:0] : v[10:9]];
         axw(cpu_exec_pkg::ACC_OFS, {24'h000000, a}, cpu_exec_pkg::RESP_OK);
         axw(cpu_exec_pkg::PSW_OFS, {24'h000000, v[27:22], v[20], v[8]}, cpu_exec_pkg::RESP_OK);
         axw(cpu_exec_pkg::PC_OFS, {15'h0000, v[31:15]}, cpu_exec_pkg::RESP_OK);
         axw(cpu_exec_pkg::ISSUE_OFS, {24'h000000, op}, cpu_exec_pkg::RESP_OK);
         e = rot(op, a, v[8]);
         `CHK("acc", e[7:0], acc)
         `CHK("carry", e[8], cy)
         `CHK("bank", v[20], bank)
         `CHK("pc", v[31:15] + 17'h00001, pc)
         axr(cpu_exec_pkg::ACC_OFS, cpu_exec_pkg::RESP_OK);
         `CHK("acc_rd", {24'h000000, e[7:0]}, d)
         axr(cpu_exec_pkg::PSW_OFS, cpu_exec_pkg::RESP_OK);
         `CHK("psw_rd", {24'h000000, v[27:22], v[20], e[8]}, d)
      end
      // opcode byte not strobed, then an opcode this block does not decode
      wstrb <= 4'he;
      axw(cpu_exec_pkg::ISSUE_OFS, 32'h000000e0, cpu_exec_pkg::RESP_OK);
      wstrb <= 4'hf;
      axw(cpu_exec_pkg::ISSUE_OFS, 32'h0000005a, cpu_exec_pkg::RESP_OK);
      `CHK("acc_kept", e[7:0], acc)
      `CHK("pc_kept", v[31:15] + 17'h00001, pc)
      `CHK("busy_ill", 1'b0, busy)
      axr(cpu_exec_pkg::STATUS_OFS, cpu_exec_pkg::RESP_OK);
      `CHK("status", 32'h00005a02, d)
      for (int i = 0; i < 10; i++) begin
         v = nxt();
         w = nxt();
         s = (i == 0) ? 16'h0001 : {v[31:24], v[7:0] | 8'h01};
         {lo, hi} = w[17:0];
         axw(cpu_exec_pkg::SP_OFS, {16'h0000, s}, cpu_exec_pkg::RESP_OK);
         axw(cpu_exec_pkg::RADDR_OFS, {26'h0, s[5:0] - 6'h01}, cpu_exec_pkg::RESP_OK);
         axw(cpu_exec_pkg::RDATA_OFS, {23'h0, lo}, cpu_exec_pkg::RESP_OK);
         axw(cpu_exec_pkg::RADDR_OFS, {26'h0, s[5:0]}, cpu_exec_pkg::RESP_OK);
         axw(cpu_exec_pkg::RDATA_OFS, {23'h0, hi}, cpu_exec_pkg::RESP_OK);
         axw(cpu_exec_pkg::NEST_OFS, {28'h0, (i == 1) ? 4'h0 : v[11:8]}, cpu_exec_pkg::RESP_OK);
         axw(cpu_exec_pkg::ISSUE_OFS, 32'h000000b0, cpu_exec_pkg::RESP_OK);
         @(posedge clk);
         `CHK("pc", {hi, lo[7:0]}, pc)
         `CHK("bank", lo[8], bank)
         `CHK("sp", s - 16'h0002, sp)
         `CHK("nest", pop((i == 1) ? 4'h0 : v[11:8]), nest)
         `CHK("busy", 1'b0, busy)
      end
      complete_run();
   end
endmodule // testbench

// ==== core/cpu_exec_pkg.sv ====
// constants and types for the return and rotate execution block
// assumes a single core clock and a synchronous active-low reset
package cpu_exec_pkg;
   // opcodes handled by this block
   localparam logic [7:0] OP_RETURN_FROM_INTERRUPT_OP     = 8'hb0;
   localparam logic [7:0] OP_ROL      = 8'he0;
   localparam logic [7:0] OP_ROTATE_LEFT_THROUGH_CARRY_OP     = 8'hf0;
   localparam logic [7:0] OP_ROR      = 8'hc0;
   localparam logic [7:0] OP_ROTATE_RIGHT_THROUGH_CARRY_OP     = 8'hd0;
   // widths
   localparam int         PC_W        = 17;
   localparam int         SP_W        = 16;
   localparam int         NEST_W      = 4;
   localparam int         RAM_AW      = 6;
   localparam int         RAM_DEPTH   = 64;
   localparam int         AXI_AW      = 8;
   // register byte offsets
   localparam logic [7:0] ISSUE_OFS   = 8'h00;
   localparam logic [7:0] ACC_OFS     = 8'h04;
   localparam logic [7:0] PSW_OFS     = 8'h08;
   localparam logic [7:0] PC_OFS      = 8'h0c;
   localparam logic [7:0] SP_OFS      = 8'h10;
   localparam logic [7:0] NEST_OFS    = 8'h14;
   localparam logic [7:0] RADDR_OFS   = 8'h18;
   localparam logic [7:0] RDATA_OFS   = 8'h1c;
   localparam logic [7:0] STATUS_OFS  = 8'h20;
   // status field positions
   localparam int         ST_BUSY_BIT = 0;
   localparam int         ST_ILL_BIT  = 1;
   localparam int         ST_OP_LSB   = 8;
   // reset values and steps
   localparam logic [7:0]      ACC_RST  = 8'h00;
   localparam logic [PC_W-1:0] PC_RST   = 17'h00000;
   localparam logic [SP_W-1:0] SP_RST   = 16'h0000;
   localparam logic [SP_W-1:0] SP_STEP  = 16'h0001;
   localparam logic [PC_W-1:0] PC_STEP  = 17'h00001;
   localparam logic [1:0]      RESP_OK  = 2'b00;
   localparam logic [1:0]      RESP_ERR = 2'b10;
   // program status flags
   typedef struct packed {
      logic [5:0] other;
      logic       register_bank_flag;
      logic       carry_flag;
   } psw_t;
   localparam psw_t PSW_RST = '{other: 6'h00, register_bank_flag: 1'b0, carry_flag: 1'b0};
   // one nine-bit stack byte
   typedef struct packed {
      logic       bit8;
      logic [7:0] data;
   } stack_byte_t;
   typedef enum logic {EX_IDLE, EX_RETURN_FROM_INTERRUPT_OP_LOAD} exec_state_t;
endpackage

// ==== core/cpu_return_from_interrupt_op_and_rotate_exec.sv ====
// execution of the return-from-interrupt and four accumulator rotate opcodes
// assumes an AXI4-Lite master for register access; interrupt acceptance is outside
//
// The register addresses and register access over AXI4-Lite were decided locally.

module cpu_return_from_interrupt_op_and_rotate_exec (
   // clock and reset
   input  wire logic                          SYS_CLK_I,
   input  wire logic                          RST_N_I,
   // axi4-lite write address and data
   input  wire logic                          S_AXI_AWVALID_I,
   output logic                               S_AXI_AWREADY_O,
   input  wire logic [cpu_exec_pkg::AXI_AW-1:0] S_AXI_AWADDR_I,
   input  wire logic                          S_AXI_WVALID_I,
   output logic                               S_AXI_WREADY_O,
   input  wire logic [31:0]                   S_AXI_WDATA_I,
   input  wire logic [3:0]                    S_AXI_WSTRB_I,
   // axi4-lite write response
   output logic                               S_AXI_BVALID_O,
   input  wire logic                          S_AXI_BREADY_I,
   output logic [1:0]                         S_AXI_BRESP_O,
   // axi4-lite read
   input  wire logic                          S_AXI_ARVALID_I,
   output logic                               S_AXI_ARREADY_O,
   input  wire logic [cpu_exec_pkg::AXI_AW-1:0] S_AXI_ARADDR_I,
   output logic                               S_AXI_RVALID_O,
   input  wire logic                          S_AXI_RREADY_I,
   output logic [31:0]                        S_AXI_RDATA_O,
   output logic [1:0]                         S_AXI_RRESP_O,
   // core state
   output logic [7:0]                         ACC_O,
   output logic                               CARRY_FLAG_O,
   output logic                               REGISTER_BANK_FLAG_O,
   output logic [cpu_exec_pkg::PC_W-1:0]      PC_O,
   output logic [cpu_exec_pkg::SP_W-1:0]      SP_O,
   output logic [cpu_exec_pkg::NEST_W-1:0]    INT_NEST_O,
   output logic                               BUSY_O
);
   // architectural state
   logic [7:0]                        acc_q, acc_d;
   cpu_exec_pkg::psw_t                psw_q, psw_d;
   logic [cpu_exec_pkg::PC_W-1:0]     pc_q, pc_d;
   logic [cpu_exec_pkg::SP_W-1:0]     sp_q, sp_d;
   logic [cpu_exec_pkg::NEST_W-1:0]   nest_q, nest_d;
   logic [cpu_exec_pkg::RAM_AW-1:0]   raddr_q, raddr_d;
   cpu_exec_pkg::exec_state_t         st_q, st_d;
   logic                              ill_q, ill_d;
   logic [7:0]                        lastop_q, lastop_d;
   cpu_exec_pkg::stack_byte_t         ram [cpu_exec_pkg::RAM_DEPTH];
   logic                              ram_we;
   logic [cpu_exec_pkg::RAM_AW-1:0]   ram_wa;
   cpu_exec_pkg::stack_byte_t         ram_wd;
   // bus state
   logic                              aw_have_q, aw_have_d;
   logic                              w_have_q, w_have_d;
   logic [cpu_exec_pkg::AXI_AW-1:0]   awaddr_q, awaddr_d;
   logic [31:0]                       wdata_q, wdata_d;
   logic [3:0]                        wstrb_q, wstrb_d;
   logic                              bvalid_q, bvalid_d;
   logic [1:0]                        bresp_q, bresp_d;
   logic                              rvalid_q, rvalid_d;
   logic [31:0]                       rdata_q, rdata_d;
   logic [1:0]                        rresp_q, rresp_d;
   logic                              wr_fire;
   logic [31:0]                       wr_val;
   logic [31:0]                       cur_val;
   logic [cpu_exec_pkg::RAM_AW-1:0]   lo_idx, hi_idx;

   // true when the byte address names a register
   function automatic logic reg_hit(input logic [cpu_exec_pkg::AXI_AW-1:0] a);
      case (a)
         cpu_exec_pkg::ISSUE_OFS, cpu_exec_pkg::ACC_OFS, cpu_exec_pkg::PSW_OFS,
         cpu_exec_pkg::PC_OFS, cpu_exec_pkg::SP_OFS, cpu_exec_pkg::NEST_OFS,
         cpu_exec_pkg::RADDR_OFS, cpu_exec_pkg::RDATA_OFS,
         cpu_exec_pkg::STATUS_OFS: reg_hit = 1'b1;
         default:                  reg_hit = 1'b0;
      endcase
   endfunction

   // current contents of a register, zero above its width
   function automatic logic [31:0] reg_value(input logic [cpu_exec_pkg::AXI_AW-1:0] a);
      reg_value = 32'h0000_0000;
      case (a)
         cpu_exec_pkg::ISSUE_OFS:  reg_value = {24'h00_0000, lastop_q};
         cpu_exec_pkg::ACC_OFS:    reg_value = {24'h00_0000, acc_q};
         cpu_exec_pkg::PSW_OFS:    reg_value = {24'h00_0000, psw_q};
         cpu_exec_pkg::PC_OFS:     reg_value = {15'h0000, pc_q};
         cpu_exec_pkg::SP_OFS:     reg_value = {16'h0000, sp_q};
         cpu_exec_pkg::NEST_OFS:   reg_value = {28'h000_0000, nest_q};
         cpu_exec_pkg::RADDR_OFS:  reg_value = {26'h000_0000, raddr_q};
         cpu_exec_pkg::RDATA_OFS:  reg_value = {23'h00_0000, ram[raddr_q]};
         cpu_exec_pkg::STATUS_OFS: begin
            reg_value[cpu_exec_pkg::ST_BUSY_BIT] = (st_q != cpu_exec_pkg::EX_IDLE);
            reg_value[cpu_exec_pkg::ST_ILL_BIT]  = ill_q;
            reg_value[cpu_exec_pkg::ST_OP_LSB +: 8] = lastop_q;
         end
         default:                  reg_value = 32'h0000_0000;
      endcase
   endfunction

   // clears the highest set nesting bit, leaving the outer levels in force
   function automatic logic [cpu_exec_pkg::NEST_W-1:0] pop_level(
      input logic [cpu_exec_pkg::NEST_W-1:0] n);
      logic done;
      done      = 1'b0;
      pop_level = n;
      for (int i = cpu_exec_pkg::NEST_W - 1; i >= 0; i--) begin
         if (!done && n[i]) begin
            pop_level[i] = 1'b0;
            done         = 1'b1;
         end
      end
   endfunction

   // bus handshakes and merged write word
   assign S_AXI_AWREADY_O = !aw_have_q;
   assign S_AXI_WREADY_O  = !w_have_q;
   assign S_AXI_ARREADY_O = !rvalid_q;
   assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
   always_comb begin
      cur_val = reg_value(awaddr_q); // unstrobed bytes keep their value
      for (int b = 0; b < 4; b++) begin
         wr_val[b*8 +: 8] = wstrb_q[b] ? wdata_q[b*8 +: 8] : cur_val[b*8 +: 8];
      end
   end

   // next state of the bus slave
   always_comb begin
      aw_have_d = aw_have_q;
      w_have_d  = w_have_q;
      awaddr_d  = awaddr_q;
      wdata_d   = wdata_q;
      wstrb_d   = wstrb_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      rvalid_d  = rvalid_q;
      rdata_d   = rdata_q;
      rresp_d   = rresp_q;
      if (S_AXI_AWVALID_I && !aw_have_q) begin
         aw_have_d = 1'b1;
         awaddr_d  = S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && !w_have_q) begin
         w_have_d = 1'b1;
         wdata_d  = S_AXI_WDATA_I;
         wstrb_d  = S_AXI_WSTRB_I;
      end
      if (bvalid_q && S_AXI_BREADY_I) begin
         bvalid_d = 1'b0;
      end
      if (wr_fire) begin
         aw_have_d = 1'b0;
         w_have_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = reg_hit(awaddr_q) ? cpu_exec_pkg::RESP_OK : cpu_exec_pkg::RESP_ERR;
      end
      if (rvalid_q && S_AXI_RREADY_I) begin
         rvalid_d = 1'b0;
      end
      if (S_AXI_ARVALID_I && !rvalid_q) begin
         rvalid_d = 1'b1;
         rdata_d  = reg_value(S_AXI_ARADDR_I);
         rresp_d  = reg_hit(S_AXI_ARADDR_I) ? cpu_exec_pkg::RESP_OK : cpu_exec_pkg::RESP_ERR;
      end
   end

   // bus slave registers
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         awaddr_q  <= '0;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= cpu_exec_pkg::RESP_OK;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= cpu_exec_pkg::RESP_OK;
      end else begin
         aw_have_q <= aw_have_d;
         w_have_q  <= w_have_d;
         awaddr_q  <= awaddr_d;
         wdata_q   <= wdata_d;
         wstrb_q   <= wstrb_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         rvalid_q  <= rvalid_d;
         rdata_q   <= rdata_d;
         rresp_q   <= rresp_d;
      end
   end

   // stack word indices after the first pointer decrement
   assign lo_idx = sp_q[cpu_exec_pkg::RAM_AW-1:0];
   assign hi_idx = 6'(lo_idx + 6'h01); // wraps inside the stack ram

   // next state of the execution core
   always_comb begin
      acc_d    = acc_q;
      psw_d    = psw_q;
      pc_d     = pc_q;
      sp_d     = sp_q;
      nest_d   = nest_q;
      raddr_d  = raddr_q;
      st_d     = st_q;
      ill_d    = ill_q;
      lastop_d = lastop_q;
      ram_we   = 1'b0;
      ram_wa   = raddr_q;
      ram_wd   = wr_val[8:0];
      case (st_q)
         cpu_exec_pkg::EX_IDLE: begin
            if (wr_fire && awaddr_q == cpu_exec_pkg::ISSUE_OFS && wstrb_q[0]) begin
               lastop_d = wdata_q[7:0];
               ill_d    = 1'b0;
               case (wdata_q[7:0])
                  cpu_exec_pkg::OP_RETURN_FROM_INTERRUPT_OP: begin
                     sp_d = sp_q - cpu_exec_pkg::SP_STEP;
                     st_d = cpu_exec_pkg::EX_RETURN_FROM_INTERRUPT_OP_LOAD;
                  end
                  cpu_exec_pkg::OP_ROL: begin
                     acc_d = {acc_q[6:0], acc_q[7]};
                     pc_d  = pc_q + cpu_exec_pkg::PC_STEP;
                  end
                  cpu_exec_pkg::OP_ROTATE_LEFT_THROUGH_CARRY_OP: begin
                     acc_d            = {acc_q[6:0], psw_q.carry_flag};
                     psw_d.carry_flag = acc_q[7];
                     pc_d             = pc_q + cpu_exec_pkg::PC_STEP;
                  end
                  cpu_exec_pkg::OP_ROR: begin
                     acc_d = {acc_q[0], acc_q[7:1]};
                     pc_d  = pc_q + cpu_exec_pkg::PC_STEP;
                  end
                  cpu_exec_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY_OP: begin
                     acc_d            = {psw_q.carry_flag, acc_q[7:1]};
                     psw_d.carry_flag = acc_q[0];
                     pc_d             = pc_q + cpu_exec_pkg::PC_STEP;
                  end
                  default: ill_d = 1'b1; // not an opcode of this block
               endcase
            end else if (wr_fire) begin
               // state writes from software, accepted only while idle
               case (awaddr_q)
                  cpu_exec_pkg::ACC_OFS:   acc_d   = wr_val[7:0];
                  cpu_exec_pkg::PSW_OFS:   psw_d   = wr_val[7:0];
                  cpu_exec_pkg::PC_OFS:    pc_d    = wr_val[cpu_exec_pkg::PC_W-1:0];
                  cpu_exec_pkg::SP_OFS:    sp_d    = wr_val[cpu_exec_pkg::SP_W-1:0];
                  cpu_exec_pkg::NEST_OFS:  nest_d  = wr_val[cpu_exec_pkg::NEST_W-1:0];
                  cpu_exec_pkg::RADDR_OFS: raddr_d = wr_val[cpu_exec_pkg::RAM_AW-1:0];
                  cpu_exec_pkg::RDATA_OFS: ram_we  = 1'b1;
                  default:                 ram_we  = 1'b0;
               endcase
            end
         end
         cpu_exec_pkg::EX_RETURN_FROM_INTERRUPT_OP_LOAD: begin
            // second cycle: load pc from the stacked word and drop the pointer again in the same cycle
            pc_d = {ram[hi_idx].bit8, ram[hi_idx].data, ram[lo_idx].data};
            psw_d.register_bank_flag = ram[lo_idx].bit8;
            sp_d   = sp_q - cpu_exec_pkg::SP_STEP;
            nest_d = pop_level(nest_q);
            st_d   = cpu_exec_pkg::EX_IDLE;
         end
         default: st_d = cpu_exec_pkg::EX_IDLE;
      endcase
   end

   // core registers
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         acc_q    <= cpu_exec_pkg::ACC_RST;
         psw_q    <= cpu_exec_pkg::PSW_RST;
         pc_q     <= cpu_exec_pkg::PC_RST;
         sp_q     <= cpu_exec_pkg::SP_RST;
         nest_q   <= '0;
         raddr_q  <= '0;
         st_q     <= cpu_exec_pkg::EX_IDLE;
         ill_q    <= 1'b0;
         lastop_q <= 8'h00;
      end else begin
         acc_q    <= acc_d;
         psw_q    <= psw_d;
         pc_q     <= pc_d;
         sp_q     <= sp_d;
         nest_q   <= nest_d;
         raddr_q  <= raddr_d;
         st_q     <= st_d;
         ill_q    <= ill_d;
         lastop_q <= lastop_d;
      end
   end

   // stack ram, loaded by software through the data window
   always_ff @(posedge SYS_CLK_I) begin
      if (ram_we) begin
         ram[ram_wa] <= ram_wd;
      end
   end

   // outputs
   assign S_AXI_BVALID_O       = bvalid_q;
   assign S_AXI_BRESP_O        = bresp_q;
   assign S_AXI_RVALID_O       = rvalid_q;
   assign S_AXI_RDATA_O        = rdata_q;
   assign S_AXI_RRESP_O        = rresp_q;
   assign ACC_O                = acc_q;
   assign CARRY_FLAG_O         = psw_q.carry_flag;
   assign REGISTER_BANK_FLAG_O = psw_q.register_bank_flag;
   assign PC_O                 = pc_q;
   assign SP_O                 = sp_q;
   assign INT_NEST_O           = nest_q;
   assign BUSY_O               = (st_q != cpu_exec_pkg::EX_IDLE);
endmodule // cpu_return_from_interrupt_op_and_rotate_exec
